// File: pfs_pkg.sv
// Overview of operation
// - Group A bit 7: line 15 or infrared transmit
// - Group A bit 6: line 14 or watchdog
// - Group A bit 5: lines 12/13 or two-wire bus
// - Group A bit 4 reads zero, line 11
// - Group A bit 2: line 10 or SMI
// - Group A bit 1: gate A20, resets one
// - Group A bit 0: keyboard reset, resets one
// - Group B 7-6: line 32, port16, infrared select 1
// - Group B bit 5: lines 30/31 or MIDI
// - Group B bit 4: lines 20-27 or joysticks
// - Group B 3-2: line 17, drive 1, infrared 3
// - Group B 1-0: line 16, motor 1, infrared 2
// - Route code 000 routes no identification inputs
// - Code 001: lines 11,12,13,16,17, first processor
// - Code 010: lines 5,12,13,14,32, first processor
// - Code 011: processor select picks line group
// - Code 100: lines 11,12,13,16,17, line 14 drives select
// - Lock freezes selects; only reset clears it
package pfs_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_LOCK = 8'h21;
  localparam logic [7:0] OFS_GROUP_A = 8'h23;
  localparam logic [7:0] OFS_GROUP_B = 8'h24;
  localparam logic [7:0] OFS_GROUP_C = 8'h25;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_A = 8'h03;
  localparam logic [7:0] RST_B = 8'h00;
  localparam logic [7:0] RST_C = 8'h00;
  localparam logic [7:0] WMASK_A = 8'hE7;
  localparam logic [7:0] WMASK_B = 8'hFF;
  localparam logic [7:0] WMASK_C = 8'hE0;

  // Field positions
  localparam int LOCK_BIT = 7;
  localparam int A_IR_TX_BIT = 7;
  localparam int A_WDOG_BIT = 6;
  localparam int A_TWB_BIT = 5;
  localparam int A_SMI_BIT = 2;
  localparam int A_GATE_BIT = 1;
  localparam int A_KBD_RST_BIT = 0;
  localparam int B_P127_LSB = 6;
  localparam int B_MIDI_BIT = 5;
  localparam int B_JOY_BIT = 4;
  localparam int B_P71_LSB = 2;
  localparam int B_P69_LSB = 0;
  localparam int C_ROUTE_LSB = 5;

  // Pin and line counts
  localparam int NUM_PINS = 21;
  localparam int NUM_GP = 33;
  localparam int VID_W = 5;
  localparam int NUM_JOY = 8;

  // Pin slots in the shared pad array; GP14 is line 14, not a slot
  localparam int P57 = 0;
  localparam int P56 = 1;
  localparam int P54 = 2;
  localparam int P55 = 3;
  localparam int P53 = 4;
  localparam int PIN21 = 5;
  localparam int P9 = 6;
  localparam int P8 = 7;
  localparam int P127 = 8;
  localparam int P125 = 9;
  localparam int P126 = 10;
  localparam int PJOY = 11;
  localparam int P71 = 19;
  localparam int P69 = 20;
  localparam int GP14 = 14;

  typedef logic [5:0] pfs_line_t;

  // General-purpose line carried by each pin slot
  localparam pfs_line_t PIN_GP_LINE [NUM_PINS] = '{
    6'h0F, 6'h0E, 6'h0C, 6'h0D, 6'h0B, 6'h0A, 6'h07, 6'h06, 6'h20, 6'h1E, 6'h1F,
    6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h11, 6'h10};

  // Identification source lines, bit 0 first
  localparam pfs_line_t VID_SRC_A [VID_W] = '{6'h0B, 6'h0C, 6'h0D, 6'h10, 6'h11};
  localparam pfs_line_t VID_SRC_B [VID_W] = '{6'h05, 6'h0C, 6'h0D, 6'h0E, 6'h20};
  localparam pfs_line_t VID_SRC_C0 [VID_W] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h18};
  localparam pfs_line_t VID_SRC_C1 [VID_W] = '{6'h19, 6'h1A, 6'h1B, 6'h1E, 6'h1F};

  // Identification route codes
  typedef enum logic [2:0] {
    ROUTE_NONE = 3'h0,
    ROUTE_FIRST_A = 3'h1,
    ROUTE_FIRST_B = 3'h2,
    ROUTE_DUAL = 3'h3,
    ROUTE_CTRL = 3'h4
  } pfs_route_t;

  // One pad drive: level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } pfs_drive_t;

  // Alternate functions that drive pins
  typedef struct packed {
    pfs_drive_t infrared_transmit;
    pfs_drive_t watchdog;
    pfs_drive_t scl;
    pfs_drive_t sda;
    pfs_drive_t smi;
    pfs_drive_t gateA20;
    pfs_drive_t kbdRst;
    pfs_drive_t kbdBit16;
    pfs_drive_t irSel1;
    pfs_drive_t irSel2;
    pfs_drive_t irSel3;
    pfs_drive_t midiTx;
    pfs_drive_t drvSel1;
    pfs_drive_t motorEn1;
  } pfs_alt_drive_t;

  // Alternate functions that sense pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic kbdBit16;
    logic midiRx;
    logic [NUM_JOY-1:0] joy;
  } pfs_alt_sense_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfs_bus_req_t;

endpackage : pfs_pkg

// File: pfs_pin_cell.sv
`timescale 1ns/10ps
// One shared pad: picks one of four functions, syncs the pad input
module pfs_pin_cell (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] sel,
  input pfs_pkg::pfs_drive_t [3:0] fnDrive,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic [3:0] fnSense
);

  logic padSync1_reg; // First synchroniser stage
  logic padSync2_reg; // Second synchroniser stage
  logic [3:0] fnSense_next; // Input handed to the selected function only
  pfs_pkg::pfs_drive_t drive_next; // Drive of the selected function

  // Selected function owns the pad; code 3 leaves it idle
  assign drive_next = fnDrive[sel];
  assign fnSense_next = 4'h1 << sel;

  // Synchroniser for the pad input
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      padSync1_reg <= 1'b0;
      padSync2_reg <= 1'b0;
    end
    else
    begin
      padSync1_reg <= padIn;
      padSync2_reg <= padSync1_reg;
    end
  end

  // Registered pad drive and gated sense
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      padOut <= 1'b0;
      padOe <= 1'b0;
      fnSense <= 4'h0;
    end
    else
    begin
      padOut <= drive_next.out;
      padOe <= drive_next.oe;
      fnSense <= padSync2_reg ? fnSense_next : 4'h0;
    end
  end

endmodule : pfs_pin_cell

// File: pfs_vid_route.sv
`timescale 1ns/10ps
// Routes general-purpose inputs to the voltage monitor identification bits
module pfs_vid_route (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] routeCode,
  input wire logic cpuSelect,
  input wire logic [pfs_pkg::NUM_GP-1:0] gpSense,
  input wire logic gpLine5In,
  output logic [pfs_pkg::VID_W-1:0] vidBits,
  output logic vidRouteEn,
  output logic procSelActive
);

  logic [pfs_pkg::NUM_GP-1:0] lines; // Sensed lines with line 5 merged in
  logic [pfs_pkg::VID_W-1:0] vid_next; // Selected identification value
  logic routeEn_next; // A valid route code is in force

  // Gather five lines named by a table
  function automatic logic [pfs_pkg::VID_W-1:0] pick(
    input logic [pfs_pkg::NUM_GP-1:0] src,
    input pfs_pkg::pfs_line_t tbl [pfs_pkg::VID_W]);
    logic [pfs_pkg::VID_W-1:0] r;
    r = '0;
    for (int i = 0; i < pfs_pkg::VID_W; i++)
      r[i] = src[tbl[i]];
    return r;
  endfunction : pick

  assign lines = gpSense | ({{(pfs_pkg::NUM_GP-1){1'b0}}, gpLine5In} << 5);
  assign procSelActive = (routeCode == pfs_pkg::ROUTE_CTRL);

  // Route decode; reserved codes route nothing
  always_comb
  begin
    vid_next = '0;
    routeEn_next = 1'b1;
    case (routeCode)
      pfs_pkg::ROUTE_FIRST_A: vid_next = pick(lines, pfs_pkg::VID_SRC_A);
      pfs_pkg::ROUTE_FIRST_B: vid_next = pick(lines, pfs_pkg::VID_SRC_B);
      pfs_pkg::ROUTE_DUAL: vid_next = cpuSelect ? pick(lines, pfs_pkg::VID_SRC_C1)
                                                : pick(lines, pfs_pkg::VID_SRC_C0);
      pfs_pkg::ROUTE_CTRL: vid_next = pick(lines, pfs_pkg::VID_SRC_A);
      default: routeEn_next = 1'b0;
    endcase
  end

  // Registered identification value
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      vidBits <= '0;
      vidRouteEn <= 1'b0;
    end
    else
    begin
      vidBits <= vid_next;
      vidRouteEn <= routeEn_next;
    end
  end

  a_vid_none: assert property (@(posedge clk_sys) disable iff (reset)
    (routeCode == 3'h0) |=> (!vidRouteEn && vidBits == 5'h00))
    else $error("route code 0 must route nothing");
  a_vid_dual_cpu: assert property (@(posedge clk_sys) disable iff (reset)
    (routeCode == 3'h3 && cpuSelect) |=> (vidBits == {$past(lines[31]), $past(lines[30]),
      $past(lines[27]), $past(lines[26]), $past(lines[25])}))
    else $error("second processor lines not routed");
  a_vid_code_a: assert property (@(posedge clk_sys) disable iff (reset)
    (routeCode == 3'h1) |=> (vidRouteEn && vidBits[0] == $past(lines[11])))
    else $error("code 1 line 11 not routed");

endmodule : pfs_vid_route

// File: pfs_pin_mux.sv
// Strobed register access was decided locally.
`timescale 1ns/10ps
// Pin function select registers and the shared pad multiplexer
module pfs_pin_mux (
  input wire logic clk_sys,
  input wire logic reset,
  input pfs_pkg::pfs_bus_req_t busReq,
  output logic [pfs_pkg::DATA_W-1:0] rdData,
  input pfs_pkg::pfs_drive_t [pfs_pkg::NUM_GP-1:0] gpDrive,
  output logic [pfs_pkg::NUM_GP-1:0] gpSense,
  input wire logic gpLine5In,
  input pfs_pkg::pfs_alt_drive_t altDrive,
  output pfs_pkg::pfs_alt_sense_t altSense,
  input wire logic [pfs_pkg::NUM_PINS-1:0] padIn,
  output logic [pfs_pkg::NUM_PINS-1:0] padOut,
  output logic [pfs_pkg::NUM_PINS-1:0] padOe,
  input wire logic cpuSelect,
  output logic [pfs_pkg::VID_W-1:0] vidBits,
  output logic vidRouteEn,
  output logic lockActive
);

  // Select registers and lock
  logic [7:0] regA_reg; // Group A selects
  logic [7:0] regB_reg; // Group B selects
  logic [7:0] regC_reg; // Group C route code
  logic [7:0] regA_next;
  logic [7:0] regB_next;
  logic [7:0] regC_next;
  logic lock_reg; // Select lock, sticky until reset
  logic lock_next;
  logic [7:0] rdData_next; // Read data for the next cycle

  // Bus decode
  wire hitLock = (busReq.addr == pfs_pkg::OFS_LOCK);
  wire hitA = (busReq.addr == pfs_pkg::OFS_GROUP_A);
  wire hitB = (busReq.addr == pfs_pkg::OFS_GROUP_B);
  wire hitC = (busReq.addr == pfs_pkg::OFS_GROUP_C);
  wire wrOpen = busReq.wr && !lock_reg; // Select writes pass only unlocked
  wire wrA = wrOpen && hitA;
  wire wrB = wrOpen && hitB;
  wire wrC = wrOpen && hitC;

  // Merge write data into writable bits only
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] data,
    input logic [7:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction : merge

  // Next register values; fixed bits keep their reset zeros
  assign regA_next = wrA ? merge(regA_reg, busReq.wdata, pfs_pkg::WMASK_A) : regA_reg;
  assign regB_next = wrB ? merge(regB_reg, busReq.wdata, pfs_pkg::WMASK_B) : regB_reg;
  assign regC_next = wrC ? merge(regC_reg, busReq.wdata, pfs_pkg::WMASK_C) : regC_reg;
  assign lock_next = lock_reg | (busReq.wr && hitLock && busReq.wdata[pfs_pkg::LOCK_BIT]);

  // Read selection; unmapped offsets read zero
  assign rdData_next = !busReq.rd ? 8'h00 :
                       hitLock ? {lock_reg, 7'h00} :
                       hitA ? regA_reg :
                       hitB ? regB_reg :
                       hitC ? regC_reg : 8'h00;

  // Register file
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      regA_reg <= pfs_pkg::RST_A;
      regB_reg <= pfs_pkg::RST_B;
      regC_reg <= pfs_pkg::RST_C;
      lock_reg <= 1'b0;
      rdData <= 8'h00;
    end
    else
    begin
      regA_reg <= regA_next;
      regB_reg <= regB_next;
      regC_reg <= regC_next;
      lock_reg <= lock_next;
      rdData <= rdData_next;
    end
  end

  assign lockActive = lock_reg;

  // Identification routing
  logic [pfs_pkg::NUM_GP-1:0] gpSenseW; // Sensed general-purpose lines
  logic procSelActive; // Line 14 carries processor select
  logic [2:0] routeCode; // Route code field

  assign routeCode = regC_reg[pfs_pkg::C_ROUTE_LSB +: 3];

  pfs_vid_route u_vid (
    .clk_sys(clk_sys),
    .reset(reset),
    .routeCode(routeCode),
    .cpuSelect(cpuSelect),
    .gpSense(gpSenseW),
    .gpLine5In(gpLine5In),
    .vidBits(vidBits),
    .vidRouteEn(vidRouteEn),
    .procSelActive(procSelActive)
  );

  // Line drives, with line 14 taken over for processor select
  pfs_pkg::pfs_drive_t [pfs_pkg::NUM_GP-1:0] gpEff;
  always_comb
  begin
    gpEff = gpDrive;
    if (procSelActive)
    begin
      gpEff[pfs_pkg::GP14].out = cpuSelect;
      gpEff[pfs_pkg::GP14].oe = 1'b1;
    end
  end

  // Per-pin function code
  logic [1:0] pinSel [pfs_pkg::NUM_PINS];
  assign pinSel[pfs_pkg::P57] = {1'b0, regA_reg[pfs_pkg::A_IR_TX_BIT]};
  assign pinSel[pfs_pkg::P56] = {1'b0, regA_reg[pfs_pkg::A_WDOG_BIT]};
  assign pinSel[pfs_pkg::P54] = {1'b0, regA_reg[pfs_pkg::A_TWB_BIT]};
  assign pinSel[pfs_pkg::P55] = {1'b0, regA_reg[pfs_pkg::A_TWB_BIT]};
  assign pinSel[pfs_pkg::P53] = 2'h0;
  assign pinSel[pfs_pkg::PIN21] = {1'b0, regA_reg[pfs_pkg::A_SMI_BIT]};
  assign pinSel[pfs_pkg::P9] = {1'b0, regA_reg[pfs_pkg::A_GATE_BIT]};
  assign pinSel[pfs_pkg::P8] = {1'b0, regA_reg[pfs_pkg::A_KBD_RST_BIT]};
  assign pinSel[pfs_pkg::P127] = regB_reg[pfs_pkg::B_P127_LSB +: 2];
  assign pinSel[pfs_pkg::P125] = {1'b0, regB_reg[pfs_pkg::B_MIDI_BIT]};
  assign pinSel[pfs_pkg::P126] = {1'b0, regB_reg[pfs_pkg::B_MIDI_BIT]};
  assign pinSel[pfs_pkg::P71] = regB_reg[pfs_pkg::B_P71_LSB +: 2];
  assign pinSel[pfs_pkg::P69] = regB_reg[pfs_pkg::B_P69_LSB +: 2];

  // Joystick pins share one select bit
  genvar j;
  generate
    for (j = 0; j < pfs_pkg::NUM_JOY; j++)
    begin : g_joy
      assign pinSel[pfs_pkg::PJOY + j] = {1'b0, regB_reg[pfs_pkg::B_JOY_BIT]};
    end
  endgenerate

  // Function drive table; slot 0 is the line, code 3 idles the pad
  pfs_pkg::pfs_drive_t [3:0] fnDrv [pfs_pkg::NUM_PINS];
  always_comb
  begin
    for (int i = 0; i < pfs_pkg::NUM_PINS; i++)
    begin
      fnDrv[i] = '0;
      fnDrv[i][0] = gpEff[pfs_pkg::PIN_GP_LINE[i]];
    end
    fnDrv[pfs_pkg::P57][1] = altDrive.infrared_transmit;
    fnDrv[pfs_pkg::P56][1] = altDrive.watchdog;
    fnDrv[pfs_pkg::P54][1] = altDrive.scl;
    fnDrv[pfs_pkg::P55][1] = altDrive.sda;
    fnDrv[pfs_pkg::PIN21][1] = altDrive.smi;
    fnDrv[pfs_pkg::P9][1] = altDrive.gateA20;
    fnDrv[pfs_pkg::P8][1] = altDrive.kbdRst;
    fnDrv[pfs_pkg::P127][1] = altDrive.kbdBit16;
    fnDrv[pfs_pkg::P127][2] = altDrive.irSel1;
    fnDrv[pfs_pkg::P125][1] = altDrive.midiTx;
    fnDrv[pfs_pkg::P71][1] = altDrive.drvSel1;
    fnDrv[pfs_pkg::P71][2] = altDrive.irSel3;
    fnDrv[pfs_pkg::P69][1] = altDrive.motorEn1;
    fnDrv[pfs_pkg::P69][2] = altDrive.irSel2;
  end

  // Pad cells
  logic [3:0] cellSense [pfs_pkg::NUM_PINS];
  genvar p;
  generate
    for (p = 0; p < pfs_pkg::NUM_PINS; p++)
    begin : g_pin
      pfs_pin_cell u_cell (
        .clk_sys(clk_sys),
        .reset(reset),
        .sel(pinSel[p]),
        .fnDrive(fnDrv[p]),
        .padIn(padIn[p]),
        .padOut(padOut[p]),
        .padOe(padOe[p]),
        .fnSense(cellSense[p])
      );
    end
  endgenerate

  // Line inputs seen only while the pin is in line mode
  always_comb
  begin
    gpSenseW = '0;
    for (int i = 0; i < pfs_pkg::NUM_PINS; i++)
      gpSenseW[pfs_pkg::PIN_GP_LINE[i]] = cellSense[i][0];
  end
  assign gpSense = gpSenseW;

  // Alternate inputs
  assign altSense.scl = cellSense[pfs_pkg::P54][1];
  assign altSense.sda = cellSense[pfs_pkg::P55][1];
  assign altSense.kbdBit16 = cellSense[pfs_pkg::P127][1];
  assign altSense.midiRx = cellSense[pfs_pkg::P126][1];
  generate
    for (j = 0; j < pfs_pkg::NUM_JOY; j++)
    begin : g_joy_in
      assign altSense.joy[j] = cellSense[pfs_pkg::PJOY + j][1];
    end
  endgenerate

  // Checks
  a_lock_freeze: assert property (@(posedge clk_sys) disable iff (reset)
    (lock_reg && busReq.wr) |=> ($stable(regA_reg) && $stable(regB_reg) && $stable(regC_reg)))
    else $error("select register changed while locked");
  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    lock_reg |=> lock_reg)
    else $error("lock cleared without reset");
  a_fixed_bits: assert property (@(posedge clk_sys) disable iff (reset)
    (regA_reg[4:3] == 2'h0) && (regC_reg[4:0] == 5'h00))
    else $error("read-only or reserved bit changed");
  a_infrared_transmit_pad: assert property (@(posedge clk_sys) disable iff (reset)
    !reset |=> (padOut[0] == $past(regA_reg[7] ? altDrive.infrared_transmit.out : gpDrive[15].out)))
    else $error("pin 57 drive does not follow select");
  a_gate_a20_out_pad: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset && regA_reg[1]) |=> (padOe[6] == $past(altDrive.gateA20.oe)))
    else $error("gate A20 not on its pin");
  a_twowire_pad: assert property (@(posedge clk_sys) disable iff (reset)
    regA_reg[5] |=> (padOe[2] == $past(altDrive.scl.oe) && padOe[3] == $past(altDrive.sda.oe)))
    else $error("two-wire bus not on its pins");
  a_proc_select: assert property (@(posedge clk_sys) disable iff (reset)
    (regC_reg[7:5] == 3'h4 && !regA_reg[6]) |=> (padOe[1] && padOut[1] == $past(cpuSelect)))
    else $error("line 14 not driving processor select");
  a_p127_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    (regB_reg[7:6] == 2'h3) |=> !padOe[8])
    else $error("reserved code drives pin 127");
  a_read_back: assert property (@(posedge clk_sys) disable iff (reset)
    (busReq.rd && busReq.addr == 8'h24) |=> (rdData == $past(regB_reg)))
    else $error("group B read data wrong");

  c_lock_set: cover property (@(posedge clk_sys) disable iff (reset) $rose(lock_reg));
  c_joystick: cover property (@(posedge clk_sys) disable iff (reset) regB_reg[4]);
  c_dual_cpu: cover property (@(posedge clk_sys) disable iff (reset)
    (regC_reg[7:5] == 3'h3) && cpuSelect);

endmodule : pfs_pin_mux

// File: pfs_pin_mux_tb.sv
`timescale 1ns/10ps
// Register-driven bench for the shared pad multiplexer
module pfs_pin_mux_tb;
  logic clk_sys; // System clock, 40 MHz
  logic reset; // Asynchronous reset, active high
  pfs_pkg::pfs_bus_req_t busReq; // Register bus request
  logic [pfs_pkg::DATA_W-1:0] rdData; // Read data, one cycle after the strobe
  pfs_pkg::pfs_drive_t [pfs_pkg::NUM_GP-1:0] gpDrive; // Line drives, all {1,1}
  logic [pfs_pkg::NUM_GP-1:0] gpSense; // Line inputs seen by the pads
  logic gpLine5In; // Line 5 input
  pfs_pkg::pfs_alt_drive_t altDrive; // Alternate drives, each 01 or 10, never the lines' 11
  pfs_pkg::pfs_alt_sense_t altSense; // Alternate inputs
  logic [pfs_pkg::NUM_PINS-1:0] padIn; // Raw pad levels
  logic [pfs_pkg::NUM_PINS-1:0] padOut; // Pad drive level
  logic [pfs_pkg::NUM_PINS-1:0] padOe; // Pad drive enable
  logic cpuSelect; // Processor select
  logic [pfs_pkg::VID_W-1:0] vidBits; // Identification value
  logic vidRouteEn; // Identification routing active
  logic lockActive; // Lock state
  int errCount; // Mismatches seen
  int checkCount; // Comparisons made
  logic [20:0] pv; // Pad pattern under construction
  logic l5; // Line 5 level under construction
  logic [4:0] pats [2] = '{5'h16, 5'h09}; // Identification patterns
  // Pad slot feeding each identification bit, -1 for line 5
  int vidSlot [5][5] = '{'{4, 2, 3, 20, 19}, '{-1, 2, 3, 1, 8}, '{11, 12, 13, 14, 15},
    '{16, 17, 18, 9, 10}, '{4, 2, 3, 20, 19}};
  pfs_pkg::pfs_route_t vidCode [5] = '{pfs_pkg::ROUTE_FIRST_A, pfs_pkg::ROUTE_FIRST_B,
    pfs_pkg::ROUTE_DUAL, pfs_pkg::ROUTE_DUAL, pfs_pkg::ROUTE_CTRL};
  logic vidCpu [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0}; // Processor per route row
  int bSlot [3] = '{8, 19, 20}; // Pads of the two-bit fields
  // Expected {out,oe} per code 00..11 for those pads
  logic [1:0] expB [4][3] = '{'{2'h3, 2'h3, 2'h3}, '{2'h2, 2'h1, 2'h1},
    '{2'h1, 2'h2, 2'h2}, '{2'h0, 2'h0, 2'h0}};

  // Device under test
  pfs_pin_mux i_pfs_pin_mux (
    .clk_sys(clk_sys), .reset(reset), .busReq(busReq), .rdData(rdData),
    .gpDrive(gpDrive), .gpSense(gpSense), .gpLine5In(gpLine5In), .altDrive(altDrive),
    .altSense(altSense), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .cpuSelect(cpuSelect), .vidBits(vidBits), .vidRouteEn(vidRouteEn),
    .lockActive(lockActive)
  );

  // Clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Compares a value with its expectation and counts the outcome
  task compare(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare

  // One-cycle register write
  task wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq.wr <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask : wrReg

  // One-cycle register read, data taken in the following cycle
  task rdChk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    busReq.rd <= 1'b1;
    busReq.addr <= a;
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 compare(what, rdData, e);
  endtask : rdChk

  // Lets the sense and drive pipelines settle
  task settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle

  // Checks level and enable of one pad
  task padChk(input int s, input logic [1:0] e);
    compare("pad", {6'h00, padOut[s], padOe[s]}, {6'h00, e});
  endtask : padChk

  // Prints the counts and the verdict, then stops
  task endOfTest;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : endOfTest

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    endOfTest();
  end

  // Main sequence
  initial
  begin
    reset = 1'b1;
    busReq = '0;
    gpDrive = '1;
    altDrive = 28'h66666A5; // infrared_transmit..motorEn1, {out,oe} pairs 01/10
    padIn = '0;
    gpLine5In = 1'b0;
    cpuSelect = 1'b0;
    errCount = 0;
    checkCount = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    // Reset values and unmapped read
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'h03);
    rdChk("regB", pfs_pkg::OFS_GROUP_B, 8'h00);
    rdChk("regC", pfs_pkg::OFS_GROUP_C, 8'h00);
    rdChk("lock", pfs_pkg::OFS_LOCK, 8'h00);
    rdChk("unmapped", 8'h30, 8'h00);
    @(posedge clk_sys);
    #1 compare("rdIdle", rdData, 8'h00);
    for (int s = 0; s < 6; s++)
      padChk(s, 2'h3);
    padChk(6, 2'h2);
    padChk(7, 2'h1);
    compare("routeEn", {7'h00, vidRouteEn}, 8'h00);
    $display("test reset done");
    // Group A all alternates, then all lines
    @(posedge clk_sys);
    padIn <= '1;
    wrReg(pfs_pkg::OFS_GROUP_A, 8'hFF);
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'hE7);
    settle();
    padChk(0, 2'h1);
    padChk(1, 2'h2);
    padChk(2, 2'h1);
    padChk(3, 2'h2);
    padChk(4, 2'h3);
    padChk(5, 2'h1);
    padChk(6, 2'h2);
    padChk(7, 2'h1);
    compare("twoWire", {6'h00, altSense.scl, altSense.sda}, 8'h03);
    compare("line12", {7'h00, gpSense[12]}, 8'h00);
    wrReg(pfs_pkg::OFS_GROUP_A, 8'h00);
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'h00);
    settle();
    padChk(0, 2'h3);
    padChk(6, 2'h3);
    padChk(7, 2'h3);
    compare("line12", {7'h00, gpSense[12]}, 8'h01);
    compare("twoWire", {6'h00, altSense.scl, altSense.sda}, 8'h00);
    $display("test group a done");
    // Two-bit fields through every code
    for (int c = 0; c < 4; c++)
    begin
      wrReg(pfs_pkg::OFS_GROUP_B, {c[1:0], 2'h0, c[1:0], c[1:0]});
      rdChk("regB", pfs_pkg::OFS_GROUP_B, {c[1:0], 2'h0, c[1:0], c[1:0]});
      settle();
      for (int k = 0; k < 3; k++)
      begin
        compare("fieldOe", {7'h00, padOe[bSlot[k]]}, {7'h00, expB[c][k][0]});
        if (c < 3)
          compare("fieldOut", {7'h00, padOut[bSlot[k]]}, {7'h00, expB[c][k][1]});
      end
      compare("p127Sense", {6'h00, altSense.kbdBit16, gpSense[32]}, {6'h00, c == 1, c == 0});
    end
    $display("test group b fields done");
    // MIDI and joystick pads
    @(posedge clk_sys);
    padIn <= 21'h052C00;
    wrReg(pfs_pkg::OFS_GROUP_B, 8'h30);
    settle();
    padChk(9, 2'h2);
    compare("midiRxOe", {7'h00, padOe[10]}, 8'h00);
    compare("midiRx", {7'h00, altSense.midiRx}, 8'h01);
    compare("joy", altSense.joy, 8'hA5);
    compare("joyOe", padOe[18:11], 8'h00);
    compare("joyLines", gpSense[27:20], 8'h00);
    wrReg(pfs_pkg::OFS_GROUP_B, 8'h00);
    settle();
    compare("joyLines", gpSense[27:20], 8'hA5);
    compare("midiLines", {6'h00, gpSense[31:30]}, 8'h02);
    compare("joy", altSense.joy, 8'h00);
    $display("test group b pairs done");
    // Identification routes
    for (int r = 0; r < 5; r++)
    begin
      @(posedge clk_sys);
      cpuSelect <= vidCpu[r];
      wrReg(pfs_pkg::OFS_GROUP_C, {vidCode[r], 5'h00});
      for (int p = 0; p < 2; p++)
      begin
        pv = '0;
        l5 = 1'b0;
        for (int b = 0; b < 5; b++)
          if (vidSlot[r][b] < 0)
            l5 = pats[p][b];
          else
            pv[vidSlot[r][b]] = pats[p][b];
        @(posedge clk_sys);
        padIn <= pv;
        gpLine5In <= l5;
        settle();
        compare("vid", {3'h0, vidBits}, {3'h0, pats[p]});
        compare("routeEn", {7'h00, vidRouteEn}, 8'h01);
      end
    end
    @(posedge clk_sys);
    cpuSelect <= 1'b0;
    settle();
    padChk(1, 2'h1);
    @(posedge clk_sys);
    cpuSelect <= 1'b1;
    settle();
    padChk(1, 2'h3);
    wrReg(pfs_pkg::OFS_GROUP_C, 8'hFF);
    rdChk("regC", pfs_pkg::OFS_GROUP_C, 8'hE0);
    wrReg(pfs_pkg::OFS_GROUP_C, 8'h00);
    cpuSelect <= 1'b0;
    settle();
    compare("routeEn", {7'h00, vidRouteEn}, 8'h00);
    padChk(1, 2'h3);
    $display("test routes done");
    // Lock freezes all three registers until a reset
    wrReg(pfs_pkg::OFS_LOCK, 8'h80);
    rdChk("lock", pfs_pkg::OFS_LOCK, 8'h80);
    wrReg(pfs_pkg::OFS_GROUP_A, 8'hFF);
    wrReg(pfs_pkg::OFS_GROUP_B, 8'hFF);
    wrReg(pfs_pkg::OFS_GROUP_C, 8'h20);
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'h00);
    rdChk("regB", pfs_pkg::OFS_GROUP_B, 8'h00);
    rdChk("regC", pfs_pkg::OFS_GROUP_C, 8'h00);
    settle();
    compare("lockActive", {7'h00, lockActive}, 8'h01);
    padChk(0, 2'h3);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    compare("lockActive", {7'h00, lockActive}, 8'h00);
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'h03);
    wrReg(pfs_pkg::OFS_GROUP_A, 8'h80);
    rdChk("regA", pfs_pkg::OFS_GROUP_A, 8'h80);
    $display("test lock done");
    endOfTest();
  end
endmodule : pfs_pin_mux_tb
